//--- logic/adc_ctrl_pkg.sv
// adc_ctrl_pkg: register map, field positions, reset values, encodings and
// sequencing counts for the converter control block.
// assumes: 8-bit register port, one system clock, no other users of the map.
`default_nettype none

package adc_ctrl_pkg;

	// ----------------------------------------------------------------
	// bus shape
	// ----------------------------------------------------------------
	localparam int         ADDR_W        = 3;
	localparam int         DATA_W        = 8;
	localparam int         CHAN_N        = 16;
	localparam int         SRC_N         = 7;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] CTRL0_OFS     = 3'h0;
	localparam logic [2:0] CTRL1_OFS     = 3'h1;
	localparam logic [2:0] CTRL2_OFS     = 3'h2;
	localparam logic [2:0] PINSEL_LO_OFS = 3'h3;
	localparam logic [2:0] PINSEL_HI_OFS = 3'h4;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int         CHAN_LSB      = 0;
	localparam int         POWER_BIT     = 5;
	localparam int         BUSY_BIT      = 6;
	localparam int         START_BIT     = 7;
	localparam int         DIV_LSB       = 0;
	localparam int         SRC_LSB       = 4;
	localparam int         GAIN_LSB      = 0;
	localparam int         REF_LSB       = 2;
	localparam int         GAIN_IN_BIT   = 4;
	localparam int         GAIN_EN_BIT   = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CHAN_RST      = 4'h0;
	localparam logic [3:0] SRC_RST       = 4'h0;
	localparam logic [2:0] DIV_RST       = 3'h0;
	localparam logic [1:0] REF_RST       = 2'h0;
	localparam logic [1:0] GAIN_RST      = 2'h0;
	localparam logic [7:0] PINSEL_RST    = 8'h00;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] REF_SUPPLY    = 2'h0;
	localparam logic [1:0] REF_PIN       = 2'h1;
	localparam logic [3:0] CHAN_LAST_12  = 4'hB;
	// one-hot positions of the internal source taps
	localparam int         SRC_SUPPLY    = 0;
	localparam int         SRC_HALF      = 1;
	localparam int         SRC_QUARTER   = 2;
	localparam int         SRC_AMP       = 3;
	localparam int         SRC_AMP_HALF  = 4;
	localparam int         SRC_AMP_QUART = 5;
	localparam int         SRC_GROUND    = 6;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	localparam logic [3:0] SAMPLE_TICKS  = 4'h4;
	localparam logic [3:0] CONVERT_TICKS = 4'hC;

	typedef enum logic [3:0]
	{
		ST_IDLE    = 4'b0001,
		ST_ARMED   = 4'b0010,
		ST_SAMPLE  = 4'b0100,
		ST_CONVERT = 4'b1000
	} conv_state_t;

endpackage

`default_nettype wire

//--- logic/adc_source_ref_ctrl.sv
// adc_source_ref_ctrl: control side of a single successive-approximation
// converter: source and reference routing, gain amplifier settings,
// conversion clock divider, start / busy / done sequencing.
// assumes: the analog mux, amplifier and core act on the routing levels;
// the register master follows the one-cycle strobe protocol.
//
// Behaviour
// - reference comes from supply, external pin, or amplified internal reference.
// - reference field 00 supply, 01 external pin, 1x amplified reference.
// - gain amplifier power follows its enable bit.
// - two-bit gain field selects gain 1, 1.667, 2.5 or 3.333.
// - amplifier input bit picks the reference pin or the bandgap voltage.
// - internal reference choice disconnects external reference pins automatically.
// - analog assignment of a pin disables its digital function.
// - analog assignment of a pin disconnects its pull-up.
// - analog assignment overrides the port direction setting.
// - source codes 0000, 0100, 11xx route an external channel by channel field.
// - other source codes route supply taps, amplified reference taps, or ground.
// - internal source selection disconnects every external channel.
// - twelve-channel variant floats on 11xx; sixteen-channel variant uses all codes.
// - start bit pulsed low-high-low by software initiates a conversion.
// - busy flag set once conversion initiated, cleared at completion.
// - completion raises the interrupt request; busy may be polled instead.
// - conversion clock is system clock divided by two to the select value.
// - conversion lasts 16 conversion clocks: 4 sampling then 12 converting.
// - power enable bit powers the converter on when high, off when low.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none

module adc_source_ref_ctrl
#(
	parameter bit twelve_chan_variant = 1'b0
)
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// register port
	input  wire logic [2:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output var  logic [7:0]  rdata_out,
	// shared pin controls
	input  wire logic [15:0] pullup_req_in,
	input  wire logic [15:0] port_oe_req_in,
	output var  logic [15:0] pin_pullup_out,
	output var  logic [15:0] pin_oe_out,
	output var  logic [15:0] pin_digital_en_out,
	output var  logic [15:0] chan_connect_out,
	// input source routing
	output var  logic [6:0]  internal_source_out,
	// reference and gain amplifier
	output var  logic [2:0]  ref_select_out,
	output var  logic        ext_ref_pin_connect_out,
	output var  logic        gain_amp_enable_out,
	output var  logic [1:0]  gain_select_out,
	output var  logic        gain_ref_pin_connect_out,
	output var  logic        gain_bandgap_connect_out,
	// converter core
	output var  logic        converter_power_out,
	output var  logic        converter_reset_out,
	output var  logic        sample_out,
	output var  logic        convert_out,
	output var  logic        conv_tick_out,
	output var  logic        busy_out,
	output var  logic        conv_done_out
);

	// ----------------------------------------------------------------
	// software-visible state
	// ----------------------------------------------------------------
	logic [3:0]  channel_select_q;
	logic        converter_power_enable_q;
	logic        start_q;
	logic [3:0]  input_source_select_q;
	logic [2:0]  conv_clock_divider_select_q;
	logic        gain_amp_enable_q;
	logic        gain_amp_input_select_q;
	logic [1:0]  reference_source_select_q;
	logic [1:0]  gain_select_q;
	logic [15:0] pin_function_select_q;

	// sequencing state
	adc_ctrl_pkg::conv_state_t state_q;
	adc_ctrl_pkg::conv_state_t state_d;
	logic [3:0]  tick_cnt_q;
	logic [3:0]  tick_cnt_d;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic        wr_ctrl0_w;
	logic        wr_ctrl1_w;
	logic        wr_ctrl2_w;
	logic        wr_pin_lo_w;
	logic        wr_pin_hi_w;
	logic        start_new_w;
	logic        start_rise_w;
	logic        start_fall_w;

	assign wr_ctrl0_w   = wr_in & (addr_in == adc_ctrl_pkg::CTRL0_OFS);
	assign wr_ctrl1_w   = wr_in & (addr_in == adc_ctrl_pkg::CTRL1_OFS);
	assign wr_ctrl2_w   = wr_in & (addr_in == adc_ctrl_pkg::CTRL2_OFS);
	assign wr_pin_lo_w  = wr_in & (addr_in == adc_ctrl_pkg::PINSEL_LO_OFS);
	assign wr_pin_hi_w  = wr_in & (addr_in == adc_ctrl_pkg::PINSEL_HI_OFS);

	// start edges are seen on the write that changes the stored bit
	assign start_new_w  = wdata_in[adc_ctrl_pkg::START_BIT];
	assign start_rise_w = wr_ctrl0_w & start_new_w & ~start_q;
	assign start_fall_w = wr_ctrl0_w & ~start_new_w & start_q;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// control word 0: channel, power, start; busy is read-only
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			channel_select_q         <= adc_ctrl_pkg::CHAN_RST;
			converter_power_enable_q <= 1'b0;
			start_q                  <= 1'b0;
		end
		else if (wr_ctrl0_w)
		begin
			channel_select_q         <= wdata_in[adc_ctrl_pkg::CHAN_LSB +: 4];
			converter_power_enable_q <= wdata_in[adc_ctrl_pkg::POWER_BIT];
			start_q                  <= start_new_w;
		end
	end

	// control word 1: input source and divider select
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			input_source_select_q       <= adc_ctrl_pkg::SRC_RST;
			conv_clock_divider_select_q <= adc_ctrl_pkg::DIV_RST;
		end
		else if (wr_ctrl1_w)
		begin
			input_source_select_q       <= wdata_in[adc_ctrl_pkg::SRC_LSB +: 4];
			conv_clock_divider_select_q <= wdata_in[adc_ctrl_pkg::DIV_LSB +: 3];
		end
	end

	// control word 2: reference and gain amplifier
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			gain_amp_enable_q         <= 1'b0;
			gain_amp_input_select_q   <= 1'b0;
			reference_source_select_q <= adc_ctrl_pkg::REF_RST;
			gain_select_q             <= adc_ctrl_pkg::GAIN_RST;
		end
		else if (wr_ctrl2_w)
		begin
			gain_amp_enable_q         <= wdata_in[adc_ctrl_pkg::GAIN_EN_BIT];
			gain_amp_input_select_q   <= wdata_in[adc_ctrl_pkg::GAIN_IN_BIT];
			reference_source_select_q <= wdata_in[adc_ctrl_pkg::REF_LSB +: 2];
			gain_select_q             <= wdata_in[adc_ctrl_pkg::GAIN_LSB +: 2];
		end
	end

	// pin function select, one bit per shared pin, two bytes
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			pin_function_select_q <= {adc_ctrl_pkg::PINSEL_RST, adc_ctrl_pkg::PINSEL_RST};
		else if (wr_pin_lo_w)
			pin_function_select_q[7:0] <= wdata_in;
		else if (wr_pin_hi_w)
			pin_function_select_q[15:8] <= wdata_in;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] ctrl0_rd_w;
	logic [7:0] ctrl1_rd_w;
	logic [7:0] ctrl2_rd_w;
	logic [7:0] rd_mux_w;

	// unused bits and unmapped offsets read as zero
	assign ctrl0_rd_w = {start_q, busy_out, converter_power_enable_q, 1'b0, channel_select_q};
	assign ctrl1_rd_w = {input_source_select_q, 1'b0, conv_clock_divider_select_q};
	assign ctrl2_rd_w = {gain_amp_enable_q, 2'b00, gain_amp_input_select_q,
		reference_source_select_q, gain_select_q};
	assign rd_mux_w   =
		(addr_in == adc_ctrl_pkg::CTRL0_OFS)     ? ctrl0_rd_w :
		(addr_in == adc_ctrl_pkg::CTRL1_OFS)     ? ctrl1_rd_w :
		(addr_in == adc_ctrl_pkg::CTRL2_OFS)     ? ctrl2_rd_w :
		(addr_in == adc_ctrl_pkg::PINSEL_LO_OFS) ? pin_function_select_q[7:0] :
		(addr_in == adc_ctrl_pkg::PINSEL_HI_OFS) ? pin_function_select_q[15:8] :
		8'h00;

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			rdata_out <= 8'h00;
		else
			rdata_out <= rd_in ? rd_mux_w : 8'h00;
	end

	// ----------------------------------------------------------------
	// source and channel decode
	// ----------------------------------------------------------------
	logic       src_external_w;
	logic [6:0] src_internal_w;
	logic       chan_in_range_w;

	assign src_external_w = (input_source_select_q == 4'h0) |
		(input_source_select_q == 4'h4) |
		(input_source_select_q[3:2] == 2'b11);
	assign src_internal_w[adc_ctrl_pkg::SRC_SUPPLY]    = (input_source_select_q == 4'h1);
	assign src_internal_w[adc_ctrl_pkg::SRC_HALF]      = (input_source_select_q == 4'h2);
	assign src_internal_w[adc_ctrl_pkg::SRC_QUARTER]   = (input_source_select_q == 4'h3);
	assign src_internal_w[adc_ctrl_pkg::SRC_AMP]       = (input_source_select_q == 4'h5);
	assign src_internal_w[adc_ctrl_pkg::SRC_AMP_HALF]  = (input_source_select_q == 4'h6);
	assign src_internal_w[adc_ctrl_pkg::SRC_AMP_QUART] = (input_source_select_q == 4'h7);
	assign src_internal_w[adc_ctrl_pkg::SRC_GROUND]    = (input_source_select_q[3:2] == 2'b10);

	// the smaller variant leaves the input floating above channel 11
	assign chan_in_range_w = !twelve_chan_variant ||
		(channel_select_q <= adc_ctrl_pkg::CHAN_LAST_12);

	// ----------------------------------------------------------------
	// shared pins
	// ----------------------------------------------------------------
	// one cell per pin; a hit needs an external source, so internal taps
	// never meet a pin even if the channel field still points at one
	genvar pin_i;
	generate
		for (pin_i = 0; pin_i < adc_ctrl_pkg::CHAN_N; pin_i++)
		begin : g_pin
			logic hit_w;
			assign hit_w = src_external_w & chan_in_range_w &
				(channel_select_q == 4'(pin_i));
			analog_pin_cell u_cell
			(
				.clk_in           (clk_in),
				.resetn_in        (resetn_in),
				.analog_sel_in    (pin_function_select_q[pin_i]),
				.channel_hit_in   (hit_w),
				.pullup_req_in    (pullup_req_in[pin_i]),
				.port_oe_req_in   (port_oe_req_in[pin_i]),
				.pullup_out       (pin_pullup_out[pin_i]),
				.pin_oe_out       (pin_oe_out[pin_i]),
				.digital_en_out   (pin_digital_en_out[pin_i]),
				.chan_connect_out (chan_connect_out[pin_i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// analog routing outputs
	// ----------------------------------------------------------------
	logic       ref_supply_w;
	logic       ref_pin_w;
	logic       ref_amp_w;

	assign ref_supply_w = (reference_source_select_q == adc_ctrl_pkg::REF_SUPPLY);
	assign ref_pin_w    = (reference_source_select_q == adc_ctrl_pkg::REF_PIN);
	assign ref_amp_w    = reference_source_select_q[1];

	// all routing is registered so the analog switches see clean levels
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			internal_source_out      <= 7'h00;
			ref_select_out           <= 3'h1;
			ext_ref_pin_connect_out  <= 1'b0;
			gain_amp_enable_out      <= 1'b0;
			gain_select_out          <= adc_ctrl_pkg::GAIN_RST;
			gain_ref_pin_connect_out <= 1'b0;
			gain_bandgap_connect_out <= 1'b0;
			converter_power_out      <= 1'b0;
		end
		else
		begin
			internal_source_out      <= src_internal_w;
			ref_select_out           <= {ref_amp_w, ref_pin_w, ref_supply_w};
			ext_ref_pin_connect_out  <= ref_pin_w;
			gain_amp_enable_out      <= gain_amp_enable_q;
			gain_select_out          <= gain_select_q;
			gain_ref_pin_connect_out <= gain_amp_enable_q & ~gain_amp_input_select_q;
			gain_bandgap_connect_out <= gain_amp_enable_q & gain_amp_input_select_q;
			converter_power_out      <= converter_power_enable_q;
		end
	end

	// ----------------------------------------------------------------
	// conversion clock
	// ----------------------------------------------------------------
	logic begin_sample_w;

	assign begin_sample_w = (state_q == adc_ctrl_pkg::ST_ARMED) & start_fall_w &
		converter_power_enable_q;

	conv_clock_div u_div
	(
		.clk_in        (clk_in),
		.resetn_in     (resetn_in),
		.restart_in    (begin_sample_w),
		.div_select_in (conv_clock_divider_select_q),
		.tick_out      (conv_tick_out)
	);

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	logic sample_end_w;
	logic convert_end_w;

	assign sample_end_w  = conv_tick_out & (tick_cnt_q == adc_ctrl_pkg::SAMPLE_TICKS - 4'h1);
	assign convert_end_w = conv_tick_out & (tick_cnt_q == adc_ctrl_pkg::CONVERT_TICKS - 4'h1);

	// power-off aborts at once; a start rise re-arms whenever powered, even mid-run
	always_comb
	begin
		state_d = state_q;
		if (!converter_power_enable_q)
			state_d = adc_ctrl_pkg::ST_IDLE;
		else if (start_rise_w)
			state_d = adc_ctrl_pkg::ST_ARMED;
		else
		begin
			case (state_q)
				adc_ctrl_pkg::ST_IDLE:
					state_d = adc_ctrl_pkg::ST_IDLE;
				adc_ctrl_pkg::ST_ARMED:
					if (start_fall_w)
						state_d = adc_ctrl_pkg::ST_SAMPLE;
				adc_ctrl_pkg::ST_SAMPLE:
					if (sample_end_w)
						state_d = adc_ctrl_pkg::ST_CONVERT;
				adc_ctrl_pkg::ST_CONVERT:
					if (convert_end_w)
						state_d = adc_ctrl_pkg::ST_IDLE;
				default:
					state_d = adc_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	// tick counter restarts at each phase boundary
	assign tick_cnt_d =
		(state_d != state_q)                                      ? 4'h0 :
		(conv_tick_out && (state_q == adc_ctrl_pkg::ST_SAMPLE ||
			state_q == adc_ctrl_pkg::ST_CONVERT))                  ? tick_cnt_q + 4'h1 :
		tick_cnt_q;

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			state_q    <= adc_ctrl_pkg::ST_IDLE;
			tick_cnt_q <= 4'h0;
		end
		else
		begin
			state_q    <= state_d;
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// core handshake and status
	// ----------------------------------------------------------------
	logic finish_w;

	// only a full run counts as done; aborts end busy silently
	assign finish_w = (state_q == adc_ctrl_pkg::ST_CONVERT) & (state_d == adc_ctrl_pkg::ST_IDLE) &
		convert_end_w;

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			converter_reset_out <= 1'b0;
			sample_out          <= 1'b0;
			convert_out         <= 1'b0;
			busy_out            <= 1'b0;
			conv_done_out       <= 1'b0;
		end
		else
		begin
			converter_reset_out <= (state_d == adc_ctrl_pkg::ST_ARMED);
			sample_out          <= (state_d == adc_ctrl_pkg::ST_SAMPLE);
			convert_out         <= (state_d == adc_ctrl_pkg::ST_CONVERT);
			busy_out            <= (state_d == adc_ctrl_pkg::ST_SAMPLE) |
				(state_d == adc_ctrl_pkg::ST_CONVERT);
			conv_done_out       <= finish_w;
		end
	end

endmodule // adc_source_ref_ctrl

`default_nettype wire

//--- logic/analog_pin_cell.sv
// analog_pin_cell: digital side of one pin shared with an analog channel.
// assumes: port logic outside supplies its pull-up and direction requests.
`timescale 1ns/1ns
`default_nettype none

module analog_pin_cell
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// selection
	input  wire logic analog_sel_in,
	input  wire logic channel_hit_in,
	// requests from port logic
	input  wire logic pullup_req_in,
	input  wire logic port_oe_req_in,
	// pin controls
	output var  logic pullup_out,
	output var  logic pin_oe_out,
	output var  logic digital_en_out,
	output var  logic chan_connect_out
);

	// analog function wins over every digital setting of the pin
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			pullup_out       <= 1'b0;
			pin_oe_out       <= 1'b0;
			digital_en_out   <= 1'b1;
			chan_connect_out <= 1'b0;
		end
		else
		begin
			digital_en_out   <= ~analog_sel_in;
			pullup_out       <= pullup_req_in & ~analog_sel_in;
			pin_oe_out       <= port_oe_req_in & ~analog_sel_in;
			chan_connect_out <= channel_hit_in & analog_sel_in;
		end
	end

endmodule // analog_pin_cell

`default_nettype wire

//--- logic/conv_clock_div.sv
// conv_clock_div: power-of-two divider making the conversion clock tick.
// assumes: restart_in pulses when a conversion begins so phases align.
`timescale 1ns/1ns
`default_nettype none

module conv_clock_div
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// control
	input  wire logic       restart_in,
	input  wire logic [2:0] div_select_in,
	// tick
	output var  logic       tick_out
);

	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [7:0] span_w;
	logic [7:0] mask_w;
	logic       wrap_w;

	// ------------------------------------------------------------
	// terminal count
	// ------------------------------------------------------------
	// select 0 wraps every cycle, 7 every 128 cycles
	assign span_w = 8'(8'h01 << div_select_in);
	assign mask_w = span_w - 8'h01;
	assign wrap_w = (cnt_q == mask_w[6:0]);
	assign cnt_d  = restart_in ? 7'h00 : (wrap_w ? 7'h00 : cnt_q + 7'h01);

	// counter and registered tick; a restart suppresses a stale tick
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			cnt_q    <= 7'h00;
			tick_out <= 1'b0;
		end
		else
		begin
			cnt_q    <= cnt_d;
			tick_out <= wrap_w & ~restart_in;
		end
	end

endmodule // conv_clock_div

`default_nettype wire

//--- tb/adc_chk_assertions.sv
// adc_chk: port-level checks on the converter control block.
// assumes: bound to adc_source_ref_ctrl, one clock, synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module adc_chk
(
	input wire logic        clk_in, resetn_in, rd_in, ext_ref_pin_connect_out, gain_amp_enable_out,
	input wire logic        gain_ref_pin_connect_out, gain_bandgap_connect_out,
	input wire logic        busy_out, sample_out, convert_out, conv_done_out,
	input wire logic [7:0]  rdata_out,
	input wire logic [2:0]  ref_select_out,
	input wire logic [6:0]  internal_source_out,
	input wire logic [15:0] pin_pullup_out, pin_oe_out, pin_digital_en_out, chan_connect_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// read data may only appear in the cycle after a read strobe
	a_read_strobe: assert property (rdata_out != 8'h00 |-> $past(rd_in)) else $error("read data without strobe");
	a_ref_decode: assert property ($onehot(ref_select_out) && ext_ref_pin_connect_out == ref_select_out[1])
		else $error("reference routing wrong");
	a_src_isolate: assert property (|internal_source_out |-> chan_connect_out == 16'h0000)
		else $error("channel connected beside internal source");
	a_route_single: assert property ($onehot0(chan_connect_out) && $onehot0(internal_source_out))
		else $error("more than one source routed");
	a_pull_off: assert property ((pin_pullup_out & ~pin_digital_en_out) == 16'h0000)
		else $error("pull-up left on analog pin");
	a_drive_off: assert property ((pin_oe_out & ~pin_digital_en_out) == 16'h0000)
		else $error("analog pin still driven");
	a_chan_analog: assert property ((chan_connect_out & pin_digital_en_out) == 16'h0000)
		else $error("channel connected on digital pin");
	a_amp_input: assert property (gain_ref_pin_connect_out |-> gain_amp_enable_out && !gain_bandgap_connect_out)
		else $error("amplifier input select wrong");
	a_busy_sample: assert property ($rose(busy_out) |-> sample_out && !convert_out)
		else $error("busy without sampling");
	a_phase_order: assert property ($rose(convert_out) |-> $past(sample_out) && busy_out)
		else $error("convert not after sample");
	a_done_end: assert property (conv_done_out |-> !busy_out && $past(convert_out))
		else $error("done pulse out of place");
endmodule // adc_chk
bind adc_source_ref_ctrl adc_chk chk_u (.*);
`default_nettype wire

//--- tb/adc_core_model.sv
// adc_core_model: far-side converter core; counts conversion clock ticks per phase.
// assumes: one system clock; sequencer reset level clears the counts.
`timescale 1ns/1ns
`default_nettype none
module adc_core_model
(
	input  wire logic       clk_in, converter_reset_out, sample_out, convert_out, conv_tick_out,
	output var  logic [4:0] smp_ticks = 5'h00,
	output var  logic [4:0] cnv_ticks = 5'h00,
	output var  logic [7:0] tick_gap  = 8'h00
);
	logic [7:0] cyc_q = 8'h00;
	// the core only advances on ticks, so count per phase and the spacing between them
	always @(posedge clk_in)
	begin
		cyc_q <= conv_tick_out ? 8'h01 : cyc_q + 8'h01;
		if (conv_tick_out)
			tick_gap <= cyc_q;
		if (converter_reset_out)
		begin
			smp_ticks <= 5'h00;
			cnv_ticks <= 5'h00;
		end
		else if (conv_tick_out)
		begin
			smp_ticks <= smp_ticks + 5'(sample_out);
			cnv_ticks <= cnv_ticks + 5'(convert_out);
		end
	end
endmodule // adc_core_model
`default_nettype wire

//--- tb/adc_source_ref_and_conversion_control_test.sv
// testbench: routing, pin, reference and conversion scenarios on the control block.
// assumes: 100 MHz clock, register port with read data one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module adc_source_ref_and_conversion_control_test;
	logic clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0;
	logic [2:0] addr_in = 3'h0, ref_select_out;
	logic [7:0] wdata_in = 8'h00, rdata_out, tick_gap;
	logic [15:0] pullup_req_in = 16'hA5A5, port_oe_req_in = 16'h0FF0;
	logic [15:0] pin_pullup_out, pin_oe_out, pin_digital_en_out, chan_connect_out;
	logic [6:0] internal_source_out;
	logic [1:0] gain_select_out;
	logic [4:0] smp_ticks, cnv_ticks;
	logic ext_ref_pin_connect_out, gain_amp_enable_out, gain_ref_pin_connect_out, gain_bandgap_connect_out;
	logic converter_power_out, converter_reset_out, sample_out, convert_out, conv_tick_out, busy_out, conv_done_out;
	int n_fail = 0, checks_done = 0;
	adc_source_ref_ctrl dut_u (.*);
	adc_core_model core_u (.*);
	always #5 clk_in = ~clk_in;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e);
	endtask
	// routing outputs follow the register one edge after the write
	task automatic settle;
		@(posedge clk_in);
		#1;
	endtask
	task automatic t_reset;
		#1 chk(ref_select_out, 3'b001);
		chk(pin_digital_en_out, 16'hFFFF);
		wr(3'h5, 8'hFF);
		rd(3'h5, 8'h00);
		rd(3'h2, 8'h00);
	endtask
	// every reference, gain and amplifier input code, amplifier on; bandgap taken as already settled
	task automatic t_ref;
		for (logic [4:0] i = 0; i < 16; i++)
		begin
			wr(3'h2, {3'b100, i[0], i[3:0]});
			settle;
			chk(ref_select_out, i[3] ? 3'b100 : i[2] ? 3'b010 : 3'b001);
			chk(ext_ref_pin_connect_out, i[3:2] == 2'b01);
			chk(gain_select_out, i[1:0]);
			chk({gain_amp_enable_out, gain_bandgap_connect_out, gain_ref_pin_connect_out}, {1'b1, i[0], !i[0]});
		end
		wr(3'h2, 8'h10);
		settle;
		chk({gain_amp_enable_out, gain_bandgap_connect_out}, 2'b00);
	endtask
	// pins 5 and 15 analog, channel 5; sweep every source code
	task automatic t_src;
		logic [6:0] e;
		wr(3'h3, 8'h20);
		wr(3'h4, 8'h80);
		wr(3'h0, 8'h05);
		for (logic [4:0] s = 0; s < 16; s++)
		begin
			wr(3'h1, {s[3:0], 4'h0});
			settle;
			casez (s[3:0])
				4'b0001: e = 7'h01;
				4'b0010: e = 7'h02;
				4'b0011: e = 7'h04;
				4'b0101: e = 7'h08;
				4'b0110: e = 7'h10;
				4'b0111: e = 7'h20;
				4'b10??: e = 7'h40;
				default: e = 7'h00;
			endcase
			chk(internal_source_out, e);
			chk(chan_connect_out, e == 7'h00 ? 16'h0020 : 16'h0000);
		end
		// source 11xx is still external; channel 15 exists in the sixteen-channel build
		wr(3'h0, 8'h0F);
		settle;
		chk(chan_connect_out, 16'h8000);
		chk(pin_digital_en_out, 16'h7FDF);
		chk(pin_pullup_out, 16'h2585);
		chk(pin_oe_out, 16'h0FD0);
	endtask
	// divide by 64 keeps the conversion clock at 640 ns, full conversion polled on conv_done_out
	task automatic t_conv;
		int k;
		wr(3'h1, 8'h06);
		wr(3'h0, 8'h20);
		settle;
		chk(converter_power_out, 1'b1);
		repeat (20) @(posedge clk_in);
		wr(3'h0, 8'hA0);
		settle;
		chk({converter_reset_out, busy_out}, 2'b10);
		wr(3'h0, 8'h20);
		settle;
		chk({busy_out, sample_out}, 2'b11);
		rd(3'h0, 8'h60);
		k = 0;
		while (conv_done_out !== 1'b1 && k < 1200)
		begin
			settle;
			k++;
		end
		chk({conv_done_out, busy_out}, 2'b10);
		chk({smp_ticks, cnv_ticks}, {5'h04, 5'h0C});
		chk(tick_gap, 8'h40);
		settle;
		chk(conv_done_out, 1'b0);
	endtask
	task automatic end_of_test;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_reset;
		t_ref;
		t_src;
		t_conv;
		end_of_test;
	end
	// watchdog well beyond the roughly 1200 cycles the scenarios need
	initial
	begin
		#100000;
		n_fail++;
		end_of_test;
	end
endmodule // adc_source_ref_and_conversion_control_test
`default_nettype wire
